/* File: adc_timing_map.vh */
// constants for the converter timing configuration block
// assumes a 32-bit classic wishbone slave port and one 20 MHz clock
// Summary of operation
// - sample phase lasts field plus three conversion clocks
// - start-up waits (field plus one) times eight clocks
// - conversion clock period is (divider plus one) times two
// - resolution field selects 8, 10, 11, 12 bits
// - sleep bit one sleeps converter between conversions
// - read-only word, bit n shows channel n
// - presence bits fixed by build, one means present
`ifndef ADC_TIMING_MAP_VH
`define ADC_TIMING_MAP_VH
// register byte offsets
`define CFG_OFFSET 8'h08
`define PRESENCE_OFFSET 8'h30
`define CTRL_OFFSET 8'h34
`define STATUS_OFFSET 8'h38
// converter_configuration field positions
`define SLEEP_BIT 0
`define RES_LSB 4
`define RES_MSB 5
`define DIV_LSB 8
`define DIV_MSB 15
`define STARTUP_LSB 16
`define STARTUP_MSB 22
`define SHT_LSB 24
`define SHT_MSB 27
// reset value and write mask
`define CFG_RESET 32'h0000_0000
`define CFG_WMASK 32'h0f7f_ff31
// timing figures, in conversion or interface clocks
`define SHT_EXTRA 4'h3
`define STARTUP_MULT 3
`define DIV_FACTOR 2
// sequencer states
`define ST_IDLE 3'h0
`define ST_STARTUP 3'h1
`define ST_SAMPLE 3'h2
`define ST_CONVERT 3'h3
`define ST_DONE 3'h4
`endif

/* File: adc_clock_div.v */
// conversion clock tick generator from the interface clock
// assumes srst is synchronous and the divider value is stable while in use
`timescale 1ns/10ps
`default_nettype none
`include "adc_timing_map.vh"
module adc_clock_div #(
  parameter DIV_W = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire srst,
  // control
  input wire run,
  input wire [DIV_W-1:0] divider,
  // one-cycle tick per conversion clock period, on the falling half
  output reg tick_q,
  output reg conv_clk_q
);
  reg [DIV_W-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // half period is divider plus one, so a full period is twice that
  always @(posedge clk_sys) begin
    if (srst || !run) begin
      cnt_q <= {DIV_W{1'b0}};
      conv_clk_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (cnt_q == divider) begin
      cnt_q <= {DIV_W{1'b0}};
      conv_clk_q <= ~conv_clk_q;
      tick_q <= conv_clk_q; // tick on the falling half: one per period
    end else begin
      cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: adc_timing_config.v */
// converter timing configuration and conversion sequencer
// assumes a classic wishbone master on clk_sys and synchronous srst
`timescale 1ns/10ps
`default_nettype none
`include "adc_timing_map.vh"
module adc_timing_config #(
  parameter [31:0] CHANNEL_MASK = 32'h0000_00ff,
  parameter CNT_W = 12
) (
  // clock and reset
  input wire clk_sys,
  input wire srst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // converter side
  output reg conv_clk_q,
  output reg conv_sleep_q,
  output reg conv_sample_q,
  output reg conv_busy_q,
  output reg [1:0] conv_res_q,
  output reg conv_done_q
);
  reg [31:0] cfg_q;
  reg start_q;
  reg [2:0] state_q;
  reg [CNT_W-1:0] cnt_q;
  reg [3:0] bits_q;
  wire tick;
  wire clk_int;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // divider held still during start-up so sampling starts on a fresh period
  wire run_div = conv_busy_q && (state_q != `ST_STARTUP);
  wire [3:0] sht = cfg_q[`SHT_MSB:`SHT_LSB];
  wire [6:0] stup = cfg_q[`STARTUP_MSB:`STARTUP_LSB];
  wire [1:0] res = cfg_q[`RES_MSB:`RES_LSB];
  wire [CNT_W-1:0] stup_cycles;
  wire [CNT_W-1:0] sht_ticks;
  reg [3:0] res_bits;

  // start-up is counted in interface clocks
  assign stup_cycles = {{(CNT_W-8){1'b0}}, 1'b0, stup} + {{(CNT_W-1){1'b0}}, 1'b1};
  assign sht_ticks = {{(CNT_W-4){1'b0}}, sht} + {{(CNT_W-4){1'b0}}, `SHT_EXTRA};

  ////////////////////////////////////////////////////////////////////////
  // resolution decode: codes 0 to 3 give 8, 10, 11, 12 bits, one conversion step per bit
  always @* begin
    case (res)
      2'h0: res_bits = 4'h8;
      2'h1: res_bits = 4'ha;
      2'h2: res_bits = 4'hb;
      2'h3: res_bits = 4'hc;
      default: res_bits = 4'h8;
    endcase
  end

  adc_clock_div #(
    .DIV_W(8)
  ) u_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(run_div),
    .divider(cfg_q[`DIV_MSB:`DIV_LSB]),
    .tick_q(tick),
    .conv_clk_q(clk_int)
  );

  ////////////////////////////////////////////////////////////////////////
  // register bus: one wait state, ack for every access, unmapped reads zero
  always @(posedge clk_sys) begin
    if (srst) begin
      cfg_q <= `CFG_RESET;
      start_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      start_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      if (req && wb_we_i && wb_adr_i == `CFG_OFFSET) begin
        if (wb_sel_i[0]) cfg_q[7:0] <= wb_dat_i[7:0] & 8'h31;
        if (wb_sel_i[1]) cfg_q[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[2]) cfg_q[23:16] <= wb_dat_i[23:16] & 8'h7f;
        if (wb_sel_i[3]) cfg_q[31:24] <= wb_dat_i[31:24] & 8'h0f;
      end
      if (req && wb_we_i && wb_adr_i == `CTRL_OFFSET && wb_sel_i[0]) begin
        start_q <= wb_dat_i[0];
      end
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `CFG_OFFSET: wb_dat_o <= cfg_q;
          `PRESENCE_OFFSET: wb_dat_o <= CHANNEL_MASK;
          `STATUS_OFFSET: wb_dat_o <= {27'h0, conv_done_q, conv_sample_q,
                                       state_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer: start-up, sample, bit steps, done
  always @(posedge clk_sys) begin
    if (srst) begin
      state_q <= `ST_IDLE;
      cnt_q <= {CNT_W{1'b0}};
      bits_q <= 4'h0;
      conv_busy_q <= 1'b0;
      conv_sample_q <= 1'b0;
      conv_done_q <= 1'b0;
      conv_res_q <= 2'h0;
      conv_clk_q <= 1'b0;
      conv_sleep_q <= 1'b0;
    end else begin
      conv_done_q <= 1'b0;
      conv_clk_q <= clk_int;
      // asleep only when idle with sleep enabled and no start pending, awake otherwise
      conv_sleep_q <= cfg_q[`SLEEP_BIT] && state_q == `ST_IDLE && !start_q;
      case (state_q)
        `ST_IDLE: begin
          if (start_q) begin
            conv_busy_q <= 1'b1;
            conv_res_q <= res;
            bits_q <= res_bits;
            // woken converter needs start-up; an awake one skips it
            if (cfg_q[`SLEEP_BIT]) begin
              state_q <= `ST_STARTUP;
              cnt_q <= stup_cycles << `STARTUP_MULT;
            end else begin
              state_q <= `ST_SAMPLE;
              cnt_q <= sht_ticks;
              conv_sample_q <= 1'b1;
            end
          end
        end
        `ST_STARTUP: begin
          if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
            state_q <= `ST_SAMPLE;
            cnt_q <= sht_ticks;
            conv_sample_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        `ST_SAMPLE: begin
          if (tick) begin
            if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
              state_q <= `ST_CONVERT;
              conv_sample_q <= 1'b0;
            end else begin
              cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
        end
        `ST_CONVERT: begin
          // one conversion clock per result bit
          if (tick) begin
            if (bits_q == 4'h1) begin
              state_q <= `ST_DONE;
            end else begin
              bits_q <= bits_q - 4'h1;
            end
          end
        end
        `ST_DONE: begin
          conv_done_q <= 1'b1;
          conv_busy_q <= 1'b0;
          state_q <= `ST_IDLE;
        end
        default: state_q <= `ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: adc_timing_assertions.sv */
// assertions on the bus and converter outputs of adc_timing_config
// assumes binding to the design top; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module adc_timing_checker #(
  parameter [31:0] CHANNEL_MASK = 32'h0000_00ff
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // converter
  input wire logic conv_sleep_q,
  input wire logic conv_sample_q,
  input wire logic conv_busy_q,
  input wire logic conv_done_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // a read request on the edge where it is taken
  wire rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not given");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack held");
  property p_pres; rd && wb_adr_i == 8'h30 |=> wb_dat_o == CHANNEL_MASK; endproperty
  a_pres: assert property (p_pres) else $error("presence word wrong");
  property p_unm; rd && wb_adr_i == 8'h3c |=> wb_dat_o == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_done; conv_done_q |=> !conv_done_q; endproperty
  a_done: assert property (p_done) else $error("done too long");
  property p_smp; conv_sample_q |-> conv_busy_q; endproperty
  a_smp: assert property (p_smp) else $error("sample outside conversion");
  property p_slp; conv_busy_q |-> !conv_sleep_q; endproperty
  a_slp: assert property (p_slp) else $error("asleep while converting");
  // reset itself must clear, so this one is not disabled by it
  property p_rst; disable iff (1'b0) srst |=> !wb_ack_o && !conv_busy_q && !conv_sleep_q;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  c_done: cover property (conv_done_q);
  c_sleep: cover property (conv_sleep_q);
  c_pres: cover property (rd && wb_adr_i == 8'h30);
endmodule
bind adc_timing_config adc_timing_checker #(.CHANNEL_MASK(CHANNEL_MASK)) u_chk (.clk_sys,
  .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .conv_sleep_q,
  .conv_sample_q, .conv_busy_q, .conv_done_q);
`default_nettype wire

/* File: tb.sv */
// self-checking bench for adc_timing_config
// assumes the design, its map header and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "adc_timing_map.vh"
`define CHK(g,e) begin compares++; if ((g)!==(e)) begin err_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk_sys = 0, srst = 1, cyc = 0, we = 0, c0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ack, cclk, slp, smp, busy, done;
  logic [1:0] res;
  logic [3:0] bsel = 4'hf, wsel = 4'hf;
  int err_count = 0, compares = 0, n, s, p, a, b, a0, q;
  initial forever #25 clk_sys = ~clk_sys;
  adc_timing_config u_dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .conv_clk_q(cclk), .conv_sleep_q(slp), .conv_sample_q(smp),
    .conv_busy_q(busy), .conv_res_q(res), .conv_done_q(done));
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1; we <= w; adr <= ad; wdat <= d; wsel <= bsel; n = 0;
    do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 20);
    rdat = dat_o; cyc <= 0;
    if (ack !== 1'b1) begin err_count++; end_of_test; end
  endtask
  // run one conversion, measuring the sample phase and conversion clock
  task automatic conv(input logic [31:0] cfg);
    wb(1, `CFG_OFFSET, cfg); wb(1, `CTRL_OFFSET, 32'h1);
    a = 0; s = 0; p = 0; b = 0; n = 0; c0 = 0; q = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk_sys); n++;
      if (smp !== 1'b1 && s == 0) a++;
      if (smp === 1'b1) `CHK(res, cfg[5:4]);
      if (cclk === 1'b1 && c0 !== 1'b1) begin
        if (smp === 1'b1) s++;
        else if (busy === 1'b1 && s > 0) q++;
        if (b == 0) b = n; else if (p == 0) p = n - b;
      end
      c0 = cclk;
    end
    if (n >= 3000) begin err_count++; end_of_test; end
    `CHK(s, int'(cfg[27:24]) + 3);
    `CHK(p, (int'(cfg[15:8]) + 1) * 2);
    `CHK(q, (cfg[5:4] == 2'h0) ? 8 : (cfg[5:4] == 2'h1) ? 10 : (cfg[5:4] == 2'h2) ? 11 : 12);
    repeat (3) @(posedge clk_sys);
    `CHK(done, 1'b0);
    `CHK(slp, cfg[0]);
  endtask
  // reset contents, read-only word and unmapped place
  task automatic t_regs;
    wb(0, `CFG_OFFSET, 0); `CHK(rdat, 32'h0);
    `CHK(slp, 1'b0);
    wb(1, `PRESENCE_OFFSET, 32'h1234_5678); wb(0, `PRESENCE_OFFSET, 0);
    `CHK(rdat, 32'h0000_00ff);
    wb(1, `CFG_OFFSET, 32'hffff_ffff); wb(0, `CFG_OFFSET, 0); `CHK(rdat, 32'h0f7f_ff31);
    // byte lane 0 only: upper fields must keep their value
    bsel = 4'h1; wb(1, `CFG_OFFSET, 32'h0); bsel = 4'hf;
    wb(0, `CFG_OFFSET, 0); `CHK(rdat, 32'h0f7f_ff00);
    wb(0, `CTRL_OFFSET, 0); `CHK(rdat, 32'h0);
    wb(0, `STATUS_OFFSET, 0); `CHK(rdat, 32'h0);
    wb(1, 8'h3c, 32'hffff_ffff); wb(0, 8'h3c, 0); `CHK(rdat, 32'h0);
    $display("test regs done");
  endtask
  // every resolution code with sample times and dividers 0 to 3, then start-up from sleep
  task automatic t_conv;
    for (int r = 0; r < 4; r++) conv({4'h0, 4'(r), 8'h00, 8'(r), 2'h0, 2'(r), 4'h0});
    conv(32'h0005_0000); a0 = a;
    conv(32'h0005_0001); `CHK(a - a0, 48);
    $display("test conv done");
  endtask
  // reset in mid-conversion returns to the all-zero configuration
  task automatic t_rst;
    wb(1, `CFG_OFFSET, 32'h0f00_0031); wb(1, `CTRL_OFFSET, 32'h1);
    repeat (4) @(posedge clk_sys);
    srst <= 1; repeat (2) @(posedge clk_sys); srst <= 0; @(posedge clk_sys);
    `CHK(busy, 1'b0);
    wb(0, `CFG_OFFSET, 0); `CHK(rdat, 32'h0);
    $display("test rst done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 0;
    t_regs; t_conv; t_rst;
    end_of_test;
  end
endmodule
`default_nettype wire
